// [hw/tmds_defs.svh]
// constants of the twelve-month date switch: offsets, fields, resets, limits
// assumes inclusion by the package, the switch module and the test bench
`ifndef TMDS_DEFS_SVH
`define TMDS_DEFS_SVH

// register byte offsets on the avalon slave
`define TMDS_ADDR_CTRL 4'h0
`define TMDS_ADDR_ON 4'h4
`define TMDS_ADDR_OFF 4'h8
`define TMDS_ADDR_STATUS 4'hc

// control register bits
`define TMDS_CTRL_YEARLY 0
`define TMDS_CTRL_MONTHLY 1
`define TMDS_CTRL_PULSE 2
`define TMDS_CTRL_RST 3'h0

// date word layout: year [27:16], month [11:8], day [4:0]
`define TMDS_YEAR_LSB 16
`define TMDS_YEAR_MSB 27
`define TMDS_MONTH_LSB 8
`define TMDS_MONTH_MSB 11
`define TMDS_DAY_LSB 0
`define TMDS_DAY_MSB 4
`define TMDS_DATE_RST 21'h0

// status register bits; current date sits in [31:11]
`define TMDS_STAT_OUT 0
`define TMDS_STAT_ERR 1
`define TMDS_STAT_VALID 2
`define TMDS_STAT_DATE_LSB 11

// calendar limits
`define TMDS_YEAR_FIRST 12'h7d0
`define TMDS_YEAR_LAST 12'h833
`define TMDS_MONTH_FIRST 4'h1
`define TMDS_MONTH_LAST 4'hc
`define TMDS_UNSET_YEAR 12'h000
`define TMDS_UNSET_MONTH 4'h0
`define TMDS_UNSET_DAY 5'h00

`endif

// [hw/tmds_pkg.sv]
// types of the twelve-month date switch
// assumes the constants header sits beside it
package tmds_pkg;
`include "tmds_defs.svh"

    // one calendar date; a zero field means "not set"
    typedef struct packed {
        logic [11:0] year;
        logic [3:0] month;
        logic [4:0] day;
    } tmds_date_s;

    // register bus handshake states, gray along idle -> ack -> idle
    typedef enum logic [1:0] {
        TMDS_BUS_IDLE = 2'b00,
        TMDS_BUS_ACK = 2'b01
    } tmds_bus_e;

    // whole state of the switch
    typedef struct packed {
        tmds_bus_e bus;
        logic waitreq;
        logic [31:0] rdata;
        logic [2:0] ctrl;
        tmds_date_s on_date;
        tmds_date_s off_date;
        tmds_date_s sync1;
        tmds_date_s sync2;
        tmds_date_s sync3;
        tmds_date_s cur;
        logic valid;
        logic evt;
        logic out;
        logic pulsed;
        logic err;
    } tmds_state_s;

endpackage

// [hw/tmds_switch.sv]
// twelve-month date switch: date compare, output, avalon register slave
// assumes an external calendar clock drives the date pins from its own
// domain, and one clock_in cycle is one scan cycle
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`include "tmds_defs.svh"

// What this block does
// - The output only sets or clears at the midnight change of date; a pulse clears one scan later.
// - Each on and off date is read as year, then month, then day.
// - Monthly mode sets on the on day of every month, clears on the off day.
// - In repeating modes the on year is the first and the off year the last.
// - A year beyond 2099 in a date is refused and never acted on.
// - Yearly mode sets on the on month and day, clears on the off ones.
// - Pulse mode raises the output for one scan cycle at the on date.
// - Pulse works with monthly, with yearly, or alone as a single pulse.
// - With no mode set the output spans once from on date to off date.
// - A lone pulse with no off date fires only once, at the on date.
// - A yearly span crossing new year holds over it, not past the last.
// - Yearly plus monthly with no months repeats monthly over the years.
// - Dates are limited to the years 2000 through 2099.
module tmds_switch (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [3:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    input wire logic [11:0] date_year_in,
    input wire logic [3:0] date_month_in,
    input wire logic [4:0] date_day_in,
    output logic switch_out
);
    import tmds_pkg::*;

    tmds_state_s st_q;
    tmds_state_s st_d;

    // ****************************************************
    // helper functions
    // ****************************************************

    // merge a bus write into an old word under the byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    // unpack a date word, year first, month second, day third
    function automatic tmds_date_s word_to_date(input logic [31:0] w);
        tmds_date_s d;
        d.year = w[`TMDS_YEAR_MSB:`TMDS_YEAR_LSB];
        d.month = w[`TMDS_MONTH_MSB:`TMDS_MONTH_LSB];
        d.day = w[`TMDS_DAY_MSB:`TMDS_DAY_LSB];
        return d;
    endfunction

    // pack a date into its register word
    function automatic logic [31:0] date_to_word(input tmds_date_s d);
        logic [31:0] w;
        w = 32'h00000000;
        w[`TMDS_YEAR_MSB:`TMDS_YEAR_LSB] = d.year;
        w[`TMDS_MONTH_MSB:`TMDS_MONTH_LSB] = d.month;
        w[`TMDS_DAY_MSB:`TMDS_DAY_LSB] = d.day;
        return w;
    endfunction

    // a year is usable if unset or within the calendar span
    function automatic logic year_ok(input logic [11:0] y);
        return (y == `TMDS_UNSET_YEAR) ||
               ((y >= `TMDS_YEAR_FIRST) && (y <= `TMDS_YEAR_LAST));
    endfunction

    // ****************************************************
    // date compare
    // ****************************************************

    logic [11:0] last_year;
    logic [15:0] ym_now;
    logic [15:0] ym_first;
    logic [15:0] ym_last;
    logic md_wrap;
    logic d_wrap;
    logic cfg_ok;
    logic on_hit;
    logic off_hit;
    logic day_evt;
    tmds_date_s nd;

    // decide whether the newly arrived date sets or clears the output
    always_comb begin
        nd = st_q.sync3;
        last_year = (st_q.off_date.year == `TMDS_UNSET_YEAR) ?
                    `TMDS_YEAR_LAST : st_q.off_date.year;
        ym_now = {nd.year, nd.month};
        ym_first = {st_q.on_date.year,
                    (st_q.on_date.month == `TMDS_UNSET_MONTH) ?
                    `TMDS_MONTH_FIRST : st_q.on_date.month};
        ym_last = {last_year,
                   (st_q.off_date.month == `TMDS_UNSET_MONTH) ?
                   `TMDS_MONTH_LAST : st_q.off_date.month};
        md_wrap = ({st_q.on_date.month, st_q.on_date.day} >
                   {st_q.off_date.month, st_q.off_date.day}) &&
                  !st_q.ctrl[`TMDS_CTRL_PULSE];
        d_wrap = (st_q.on_date.day > st_q.off_date.day) &&
                 !st_q.ctrl[`TMDS_CTRL_PULSE];
        cfg_ok = (st_q.on_date.year != `TMDS_UNSET_YEAR) &&
                 (st_q.on_date.day != `TMDS_UNSET_DAY);
        on_hit = 1'b0;
        off_hit = 1'b0;
        if (st_q.ctrl[`TMDS_CTRL_MONTHLY]) begin
            // monthly, alone or with yearly: the on day of each month
            on_hit = (nd.day == st_q.on_date.day) && (ym_now >= ym_first) &&
                     (d_wrap ? (ym_now < ym_last) :
                      (ym_now <= ym_last));
            off_hit = (nd.day == st_q.off_date.day);
        end else if (st_q.ctrl[`TMDS_CTRL_YEARLY]) begin
            // yearly: a wrapped span needs its off date still in range
            on_hit = (nd.month == st_q.on_date.month) &&
                     (nd.day == st_q.on_date.day) &&
                     (nd.year >= st_q.on_date.year) &&
                     (md_wrap ? (nd.year < last_year) :
                      (nd.year <= last_year));
            off_hit = (nd.month == st_q.off_date.month) &&
                      (nd.day == st_q.off_date.day);
        end else begin
            // single span or single pulse: whole dates must match
            on_hit = (nd == st_q.on_date);
            off_hit = (nd == st_q.off_date);
        end
        on_hit = on_hit && cfg_ok;
        // a new date only counts once it has stood still for a scan
        // an all-zero word is the flops' reset value, never a real date
        day_evt = (st_q.sync2 == st_q.sync3) &&
                  (st_q.sync3 != `TMDS_DATE_RST) &&
                  (!st_q.valid || (st_q.sync3 != st_q.cur));
    end

    // ****************************************************
    // next state
    // ****************************************************

    logic [31:0] merged;
    tmds_date_s wdate;
    logic err_set;
    logic err_clr;

    // bus handshake, register writes, date capture and output update
    always_comb begin
        st_d = st_q;
        merged = 32'h00000000;
        wdate = `TMDS_DATE_RST;
        err_set = 1'b0;
        err_clr = 1'b0;

        // date pins cross into the scan clock through three flops
        st_d.sync1 = {date_year_in, date_month_in, date_day_in};
        st_d.sync2 = st_q.sync1;
        st_d.sync3 = st_q.sync2;

        // output: evaluated each scan, changes only on a date change or one scan after a pulse
        st_d.evt = day_evt && st_q.valid;
        if (st_q.pulsed) begin
            st_d.out = 1'b0;
            st_d.pulsed = 1'b0;
        end
        if (day_evt) begin
            st_d.cur = st_q.sync3;
            st_d.valid = 1'b1;
            if (st_q.valid) begin
                // first date after reset is a start, not a day change
                if (st_q.ctrl[`TMDS_CTRL_PULSE]) begin
                    st_d.out = on_hit;
                    st_d.pulsed = on_hit;
                end else if (off_hit) begin
                    st_d.out = 1'b0;
                end else if (on_hit) begin
                    st_d.out = 1'b1;
                end
            end
        end

        // avalon slave: one wait cycle, then one ready cycle
        case (st_q.bus)
            TMDS_BUS_IDLE: begin
                st_d.waitreq = 1'b1;
                if (read_in || write_in) begin
                    st_d.bus = TMDS_BUS_ACK;
                    st_d.waitreq = 1'b0;
                    case (address_in)
                        `TMDS_ADDR_CTRL: begin
                            st_d.rdata = {29'h0, st_q.ctrl};
                        end
                        `TMDS_ADDR_ON: begin
                            st_d.rdata = date_to_word(st_q.on_date);
                        end
                        `TMDS_ADDR_OFF: begin
                            st_d.rdata = date_to_word(st_q.off_date);
                        end
                        `TMDS_ADDR_STATUS: begin
                            st_d.rdata = {st_q.cur, 8'h00, st_q.valid,
                                          st_q.err, st_q.out};
                        end
                        default: begin
                            st_d.rdata = 32'h00000000;
                        end
                    endcase
                end
            end
            TMDS_BUS_ACK: begin
                // the master samples the ready here; writes land now
                st_d.bus = TMDS_BUS_IDLE;
                st_d.waitreq = 1'b1;
                if (write_in) begin
                    case (address_in)
                        `TMDS_ADDR_CTRL: begin
                            merged = be_merge({29'h0, st_q.ctrl},
                                              writedata_in, byteenable_in);
                            st_d.ctrl = merged[2:0];
                        end
                        `TMDS_ADDR_ON: begin
                            merged = be_merge(date_to_word(st_q.on_date),
                                              writedata_in, byteenable_in);
                            wdate = word_to_date(merged);
                            if (year_ok(wdate.year)) begin
                                st_d.on_date = wdate;
                            end else begin
                                err_set = 1'b1;
                            end
                        end
                        `TMDS_ADDR_OFF: begin
                            merged = be_merge(date_to_word(st_q.off_date),
                                              writedata_in, byteenable_in);
                            wdate = word_to_date(merged);
                            if (year_ok(wdate.year)) begin
                                st_d.off_date = wdate;
                            end else begin
                                err_set = 1'b1;
                            end
                        end
                        `TMDS_ADDR_STATUS: begin
                            err_clr = writedata_in[`TMDS_STAT_ERR] &&
                                      byteenable_in[0];
                        end
                        default: begin
                            merged = 32'h00000000;
                        end
                    endcase
                end
            end
            default: begin
                st_d.bus = TMDS_BUS_IDLE;
                st_d.waitreq = 1'b1;
            end
        endcase
        // a refused write wins over a clear in the same cycle
        st_d.err = (st_q.err && !err_clr) || err_set;
    end

    // ****************************************************
    // state register
    // ****************************************************

    // the whole state in one register, constants under reset
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            st_q.bus <= TMDS_BUS_IDLE;
            st_q.waitreq <= 1'b1;
            st_q.rdata <= 32'h00000000;
            st_q.ctrl <= `TMDS_CTRL_RST;
            st_q.on_date <= `TMDS_DATE_RST;
            st_q.off_date <= `TMDS_DATE_RST;
            st_q.sync1 <= `TMDS_DATE_RST;
            st_q.sync2 <= `TMDS_DATE_RST;
            st_q.sync3 <= `TMDS_DATE_RST;
            st_q.cur <= `TMDS_DATE_RST;
            st_q.valid <= 1'b0;
            st_q.evt <= 1'b0;
            st_q.out <= 1'b0;
            st_q.pulsed <= 1'b0;
            st_q.err <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs come straight from the state flops
    assign readdata_out = st_q.rdata;
    assign waitrequest_out = st_q.waitreq;
    assign switch_out = st_q.out;

    // ****************************************************
    // checks
    // ****************************************************

    sequence s_rise;
        !st_q.out ##1 st_q.out;
    endsequence

    sequence s_pulse_tail;
        st_q.out ##1 !st_q.out;
    endsequence

    property p_midnight_rise;
        @(posedge clock_in) disable iff (rst_in)
        s_rise |-> st_q.evt;
    endproperty
    a_midnight_rise: assert property (p_midnight_rise)
        else $error("output rose without a date change");

    property p_pulse_one;
        @(posedge clock_in) disable iff (rst_in)
        (s_rise ##0 st_q.pulsed) |-> s_pulse_tail;
    endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("pulse did not last exactly one scan");

    property p_on_year;
        @(posedge clock_in) disable iff (rst_in)
        year_ok(st_q.on_date.year);
    endproperty
    a_on_year: assert property (p_on_year)
        else $error("on year outside 2000 to 2099");

    property p_off_year;
        @(posedge clock_in) disable iff (rst_in)
        year_ok(st_q.off_date.year);
    endproperty
    a_off_year: assert property (p_off_year)
        else $error("off year outside 2000 to 2099");

    property p_reset_low;
        @(posedge clock_in)
        rst_in |=> !st_q.out [*2];
    endproperty
    a_reset_low: assert property (p_reset_low)
        else $error("output not low after reset");

    property p_span_on;
        @(posedge clock_in) disable iff (rst_in)
        ($rose(st_q.out) && (st_q.ctrl == 3'h0)) |->
            (st_q.cur == st_q.on_date);
    endproperty
    a_span_on: assert property (p_span_on)
        else $error("single span set off its on date");

    property p_yearly_on;
        @(posedge clock_in) disable iff (rst_in)
        ($rose(st_q.out) && (st_q.ctrl == 3'h1)) |->
            (st_q.cur.month == st_q.on_date.month) &&
            (st_q.cur.day == st_q.on_date.day);
    endproperty
    a_yearly_on: assert property (p_yearly_on)
        else $error("yearly set off its on month and day");

    property p_monthly_on;
        @(posedge clock_in) disable iff (rst_in)
        ($rose(st_q.out) && st_q.ctrl[`TMDS_CTRL_MONTHLY]) |->
            (st_q.cur.day == st_q.on_date.day);
    endproperty
    a_monthly_on: assert property (p_monthly_on)
        else $error("monthly set off its on day");

    property p_first_year;
        @(posedge clock_in) disable iff (rst_in)
        $rose(st_q.out) |-> (st_q.cur.year >= st_q.on_date.year);
    endproperty
    a_first_year: assert property (p_first_year)
        else $error("output set before the first year");

    property p_bus_answer;
        @(posedge clock_in) disable iff (rst_in)
        ((read_in || write_in) && (st_q.bus == TMDS_BUS_IDLE)) |=>
            !waitrequest_out ##1 waitrequest_out;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer not after one wait cycle");

endmodule

// [verification/tmds_switch_test.sv]
// self-checking bench for the twelve-month date switch
// assumes the switch module and its constants header are compiled first
`timescale 1ns/100ps
`include "tmds_defs.svh"

module tmds_switch_test;
    import tmds_pkg::*;

    // ********************************
    // signals and the design
    // ********************************
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] address_in = 4'h0;
    logic read_in = 1'b0;
    logic write_in = 1'b0;
    logic [31:0] writedata_in = 32'h0;
    logic [3:0] byteenable_in = 4'hf;
    logic [31:0] readdata_out;
    logic waitrequest_out;
    logic [11:0] date_year_in = 12'h7d7;
    logic [3:0] date_month_in = 4'h1;
    logic [4:0] date_day_in = 5'h01;
    logic switch_out;
    int bad_count = 0;
    int checked = 0;
    logic prev_lvl = 1'b0;
    logic [31:0] s;

    // 200 mhz scan clock
    always #2.5 clock_in = ~clock_in;

    tmds_switch i_dut (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .address_in(address_in),
        .read_in(read_in),
        .write_in(write_in),
        .writedata_in(writedata_in),
        .byteenable_in(byteenable_in),
        .readdata_out(readdata_out),
        .waitrequest_out(waitrequest_out),
        .date_year_in(date_year_in),
        .date_month_in(date_month_in),
        .date_day_in(date_day_in),
        .switch_out(switch_out)
    );

    // ********************************
    // verdict and comparisons
    // ********************************
    task automatic results();
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check_word(input string name, input logic [31:0] exp,
                              input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp,
                             input logic got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    // ********************************
    // avalon master: hold until waitrequest low
    // ********************************
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int n;
        @(posedge clock_in);
        read_in <= ~wr;
        write_in <= wr;
        address_in <= a;
        writedata_in <= d;
        byteenable_in <= be;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (waitrequest_out !== 1'b0 && n < 20);
        q = readdata_out;
        read_in <= 1'b0;
        write_in <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            $display("Error waitrequest expected 0 seen %b", waitrequest_out);
            results();
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be = 4'hf);
        logic [31:0] x;
        bus(1'b1, a, d, be, x);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, 4'hf, q);
    endtask

    // date word: year [27:16], month [11:8], day [4:0]
    function automatic logic [31:0] mk(input int y, input int m, input int d);
        return {4'h0, 12'(y), 4'h0, 4'(m), 3'h0, 5'(d)};
    endfunction

    task automatic cfg(input logic [2:0] c, input logic [31:0] on_w,
                       input logic [31:0] off_w);
        wr(`TMDS_ADDR_CTRL, {29'h0, c});
        wr(`TMDS_ADDR_ON, on_w);
        wr(`TMDS_ADDR_OFF, off_w);
    endtask

    // new date on the pins, then watch the output for ten scans;
    // exp: 0 low, 1 high, 2 one-scan pulse
    task automatic step(input int y, input int m, input int d, input int exp);
        int hi;
        int tg;
        logic last;
        @(posedge clock_in);
        date_year_in <= 12'(y);
        date_month_in <= 4'(m);
        date_day_in <= 5'(d);
        hi = 0;
        tg = 0;
        last = switch_out;
        repeat (10) begin
            @(posedge clock_in);
            #1;
            hi += int'(switch_out === 1'b1);
            tg += int'(switch_out !== last);
            last = switch_out;
        end
        if (exp == 2) begin
            check_word("pulse scans", 32'h1, 32'(hi));
            check_bit("level after pulse", 1'b0, last);
        end else begin
            check_bit("switch level", exp[0], last);
            check_word("switch changes", 32'(exp[0] != prev_lvl),
                       32'(tg));
            prev_lvl = exp[0];
        end
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        #1;
        check_bit("switch after reset", 1'b0, switch_out);
        check_bit("waitrequest after reset", 1'b1, waitrequest_out);
        repeat (8) @(posedge clock_in);
        check_bit("switch on start date", 1'b0, switch_out);
        rd(`TMDS_ADDR_CTRL, s);
        check_word("ctrl reset", 32'h0, s);
        rd(`TMDS_ADDR_ON, s);
        check_word("on date reset", 32'h0, s);
        rd(`TMDS_ADDR_OFF, s);
        check_word("off date reset", 32'h0, s);
        rd(4'h1, s);
        check_word("unmapped read", 32'h0, s);
        // byte enables and year limits
        wr(`TMDS_ADDR_CTRL, 32'h1);
        wr(`TMDS_ADDR_CTRL, 32'h7, 4'h0);
        rd(`TMDS_ADDR_CTRL, s);
        check_word("ctrl masked write", 32'h1, s);
        wr(`TMDS_ADDR_ON, mk(2099, 12, 31));
        rd(`TMDS_ADDR_ON, s);
        check_word("on date last year", mk(2099, 12, 31), s);
        wr(`TMDS_ADDR_ON, mk(2100, 1, 1));
        rd(`TMDS_ADDR_ON, s);
        check_word("on date beyond range", mk(2099, 12, 31), s);
        rd(`TMDS_ADDR_STATUS, s);
        check_bit("range error", 1'b1, s[`TMDS_STAT_ERR]);
        wr(`TMDS_ADDR_STATUS, 32'h2);
        rd(`TMDS_ADDR_STATUS, s);
        check_bit("range error cleared", 1'b0, s[`TMDS_STAT_ERR]);
        wr(`TMDS_ADDR_OFF, mk(1999, 12, 31));
        rd(`TMDS_ADDR_OFF, s);
        check_word("off date before range", 32'h0, s);
        rd(`TMDS_ADDR_STATUS, s);
        check_bit("range error early year", 1'b1, s[`TMDS_STAT_ERR]);
        wr(`TMDS_ADDR_STATUS, 32'h2);
        // yearly span within first and last year
        cfg(3'h1, mk(2008, 6, 1), mk(2010, 8, 31));
        step(2007, 6, 1, 0);
        step(2008, 5, 31, 0);
        step(2008, 6, 1, 1);
        rd(`TMDS_ADDR_STATUS, s);
        check_bit("status output", 1'b1, s[`TMDS_STAT_OUT]);
        check_bit("status date valid", 1'b1, s[`TMDS_STAT_VALID]);
        check_word("status date", {11'h0, 12'h7d8, 4'h6, 5'h01},
                   {11'h0, s[31:11]});
        step(2008, 7, 15, 1);
        step(2008, 8, 31, 0);
        step(2010, 6, 1, 1);
        step(2010, 8, 31, 0);
        step(2011, 6, 1, 0);
        // yearly span over new year
        cfg(3'h1, mk(2008, 12, 15), mk(2010, 1, 7));
        step(2008, 12, 15, 1);
        step(2009, 1, 1, 1);
        step(2009, 1, 7, 0);
        step(2009, 12, 15, 1);
        step(2010, 1, 7, 0);
        step(2010, 12, 15, 0);
        // monthly only
        cfg(3'h2, mk(2008, 2, 10), mk(2008, 6, 20));
        step(2008, 2, 10, 1);
        step(2008, 2, 20, 0);
        step(2008, 3, 10, 1);
        step(2008, 3, 20, 0);
        // yearly and monthly with months unset
        cfg(3'h3, mk(2008, 0, 1), mk(2010, 0, 5));
        step(2008, 1, 1, 1);
        step(2008, 1, 5, 0);
        step(2010, 12, 1, 1);
        step(2010, 12, 5, 0);
        step(2011, 1, 1, 0);
        // pulse yearly, monthly and single
        cfg(3'h5, mk(2008, 3, 15), mk(2010, 0, 0));
        step(2008, 3, 15, 2);
        step(2008, 3, 16, 0);
        step(2010, 3, 15, 2);
        step(2011, 3, 15, 0);
        cfg(3'h6, mk(2008, 0, 10), mk(0, 0, 0));
        step(2008, 4, 10, 2);
        step(2008, 4, 11, 0);
        step(2008, 5, 10, 2);
        cfg(3'h4, mk(2008, 3, 15), mk(0, 0, 0));
        step(2008, 3, 15, 2);
        step(2009, 3, 15, 0);
        // no mode: one span over years
        cfg(3'h0, mk(2008, 6, 1), mk(2010, 8, 31));
        step(2008, 6, 1, 1);
        step(2009, 8, 31, 1);
        step(2010, 8, 31, 0);
        step(2011, 6, 1, 0);
        results();
    end
endmodule
